/* File: verilog/cia_consts.svh */
// constants of the interrupt acceptance unit: offsets, fields, resets, figures
`ifndef CIA_CONSTS_SVH
`define CIA_CONSTS_SVH

// ==================================================================
// register offsets (index on the plain register port)
`define CIA_REG_FLAGS     8'h00
`define CIA_REG_PEND_LO   8'h02
`define CIA_REG_PEND_HI   8'h03
`define CIA_REG_ISP       8'h04
`define CIA_REG_USP       8'h05
`define CIA_REG_HANDLER   8'h06
`define CIA_REG_STAT      8'h07
`define CIA_REG_PRIO_BASE 8'h10

// ==================================================================
// flag register fields
`define CIA_FLG_IEN       0
`define CIA_FLG_SSEL      1
`define CIA_FLG_RSV       2
`define CIA_FLG_PL_LO     4
`define CIA_FLG_PL_HI     6

// status register fields
`define CIA_STAT_SRC_HI   4
`define CIA_STAT_BUSY     5
`define CIA_STAT_SPFAULT  6

// ==================================================================
// reset values and memory figures
`define CIA_FLAGS_RESET   1'b0
`define CIA_PL_RESET      3'h0
`define CIA_ISP_RESET     16'h0800
`define CIA_USP_RESET     16'h0800
`define CIA_RAM_BASE      16'h0400
`define CIA_VEC_BASE      16'hffdc
`define CIA_VEC_LAST      16'hffff
`define CIA_VEC_SLOTS     9
`define CIA_TRAP_U_LIMIT  6'h20
`define CIA_SP_STEP       16'h0002

// ==================================================================
// source counts
`define CIA_N_INT         14
`define CIA_N_EXT         6
`define CIA_N_HW          20
`define CIA_N_SW          4

`endif

/* File: verilog/cia_pkg.sv */
// types of the interrupt acceptance unit
package cia_pkg;

  // ==================================================================
  // acceptance sequence
  typedef enum logic [2:0] {
    CIA_IDLE,
    CIA_PUSH_PC,
    CIA_PUSH_FLG,
    CIA_FETCH,
    CIA_WAIT,
    CIA_TAKE
  } cia_state_t;

  typedef logic [2:0] cia_level_t;
  typedef logic [4:0] cia_src_t;

endpackage : cia_pkg

/* File: verilog/cia_prio_cmp.sv */
// one stage of the priority chain: keeps the better of two candidates
`timescale 1ns/1ns
module cia_prio_cmp (
  // running best
  input  wire logic             in_valid,
  input  wire cia_pkg::cia_level_t in_level,
  input  wire cia_pkg::cia_src_t in_idx,
  // candidate of this stage
  input  wire logic             cand_valid,
  input  wire cia_pkg::cia_level_t cand_level,
  input  wire cia_pkg::cia_src_t cand_idx,
  // winner
  output logic                  out_valid,
  output cia_pkg::cia_level_t   out_level,
  output cia_pkg::cia_src_t     out_idx
);

  logic take;

  // equal levels keep the earlier source: fixed order by index
  assign take      = cand_valid && (!in_valid || (cand_level > in_level));
  assign out_valid = in_valid || cand_valid;
  assign out_level = take ? cand_level : in_level;
  assign out_idx   = take ? cand_idx : in_idx;

endmodule : cia_prio_cmp

/* File: verilog/cia_top.sv */
// interrupt acceptance unit: flags, priority arbitration, context push, vector fetch
//
// Function
// - enable flag 0 blocks all maskable requests
// - acknowledge clears the maskable enable flag
// - stack select: 0 irq pointer, 1 user
// - hardware ack or trap 0-31 clears select
// - priority level is three bits, 0 to 7
// - accept hardware requests only above current priority level; software traps ignore it
// - reserved flag bit: write 0, read undefined
// - handler address fetched from table FFDC-FFFF
// - serve 14 internal, 6 external, 4 software
// - sources assigned one of seven levels
// - context pushed to stack in RAM
`timescale 1ns/1ns
`include "cia_consts.svh"
module cia_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata_q,
  // request sources
  input  wire logic [13:0] int_req,
  input  wire logic [3:0]  external_request_lines,
  input  wire logic [3:0]  key_request_lines,
  input  wire logic [3:0]  sw_req,
  input  wire logic [5:0]  trap_num,
  // core side
  input  wire logic [15:0] ret_pc,
  output logic             irq_en_q,
  output logic             stack_sel_q,
  output cia_pkg::cia_level_t processor_priority_level_q,
  output logic      [15:0] active_sp_q,
  output logic             ack_q,
  output cia_pkg::cia_src_t ack_src_q,
  output logic      [15:0] handler_q,
  output logic             handler_valid_q,
  // memory port
  output logic      [15:0] mem_addr_q,
  output logic      [15:0] mem_wdata_q,
  output logic             mem_we_q,
  output logic             mem_re_q,
  input  wire logic [15:0] mem_rdata
);

  // ==================================================================
  // state
  cia_pkg::cia_state_t state_q, state_d;
  logic [3:0]  ext_s1_q, ext_s2_q, ext_s3_q;
  logic [3:0]  key_s1_q, key_s2_q;
  logic [1:0]  key_s3_q;
  logic [`CIA_N_HW-1:0] pend_q, pend_d;
  logic [`CIA_N_SW-1:0] sw_pend_q, sw_pend_d;
  logic [5:0]  trap_num_q, trap_num_d;
  cia_pkg::cia_level_t prio_q [`CIA_N_HW];
  cia_pkg::cia_level_t prio_d [`CIA_N_HW];
  logic        irq_en_d, stack_sel_d;
  cia_pkg::cia_level_t pl_d;
  logic [15:0] isp_q, isp_d, usp_q, usp_d;
  logic [15:0] ctx_flags_q, ctx_flags_d;
  logic [3:0]  slot_q, slot_d;
  logic        sp_fault_q, sp_fault_d;
  logic [15:0] reg_rdata_d, active_sp_d;
  logic        ack_d, handler_valid_d, mem_we_d, mem_re_d;
  cia_pkg::cia_src_t ack_src_d;
  logic [15:0] handler_d, mem_addr_d, mem_wdata_d;

  // ==================================================================
  // request sources
  logic [`CIA_N_HW-1:0] hw_raise;
  logic [1:0]           key_any;
  logic [`CIA_N_HW:0]   best_v;
  cia_pkg::cia_level_t  best_l [`CIA_N_HW+1];
  cia_pkg::cia_src_t    best_i [`CIA_N_HW+1];

  // key lines fold into two sources, keeping six external in all;
  // folded after the synchroniser so two pins changing together cannot fake an edge
  assign key_any  = {|key_s2_q[3:2], |key_s2_q[1:0]};
  // synchronised pins rise into pending; internal requests are same-clock pulses
  assign hw_raise = {key_any & ~key_s3_q,
                     ext_s2_q & ~ext_s3_q,
                     int_req};

  // ==================================================================
  // priority chain
  assign best_v[0] = 1'b0;
  assign best_l[0] = 3'h0;
  assign best_i[0] = 5'h00;

  genvar g;
  generate
    for (g = 0; g < `CIA_N_HW; g++) begin : g_chain
      logic elig;
      // level 0 parks a source, leaving seven usable levels
      assign elig = pend_q[g] && irq_en_q
                 && (prio_q[g] > processor_priority_level_q);
      cia_prio_cmp u_cmp (
        .in_valid   (best_v[g]),
        .in_level   (best_l[g]),
        .in_idx     (best_i[g]),
        .cand_valid (elig),
        .cand_level (prio_q[g]),
        .cand_idx   (5'(g)),
        .out_valid  (best_v[g+1]),
        .out_level  (best_l[g+1]),
        .out_idx    (best_i[g+1])
      );
    end
  endgenerate

  // nine table slots shared by all sources
  function automatic logic [3:0] vec_slot(input logic [4:0] idx);
    return 4'(idx % 5'(`CIA_VEC_SLOTS));
  endfunction : vec_slot

  // ==================================================================
  // next state
  always_comb begin
    logic [15:0] sp;
    logic [15:0] sp_new;
    logic        accept;
    logic        clr_sel;
    logic [4:0]  src;
    sp          = stack_sel_q ? usp_q : isp_q;
    sp_new      = sp - `CIA_SP_STEP;
    accept      = 1'b0;
    clr_sel     = 1'b0;
    src         = 5'h00;
    state_d     = state_q;
    sw_pend_d   = sw_pend_q | sw_req;
    trap_num_d  = (|sw_req) ? trap_num : trap_num_q;
    pend_d      = pend_q | hw_raise;
    prio_d      = prio_q;
    irq_en_d    = irq_en_q;
    stack_sel_d = stack_sel_q;
    pl_d        = processor_priority_level_q;
    isp_d       = isp_q;
    usp_d       = usp_q;
    ctx_flags_d = ctx_flags_q;
    slot_d      = slot_q;
    sp_fault_d  = sp_fault_q;
    reg_rdata_d = 16'h0000;
    ack_d       = 1'b0;
    ack_src_d   = ack_src_q;
    handler_d   = handler_q;
    handler_valid_d = 1'b0;
    mem_addr_d  = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    mem_we_d    = 1'b0;
    mem_re_d    = 1'b0;

    // register writes; reserved flag bit is dropped
    if (reg_wr) begin
      unique case (reg_addr)
        `CIA_REG_FLAGS: begin
          irq_en_d    = reg_wdata[`CIA_FLG_IEN];
          stack_sel_d = reg_wdata[`CIA_FLG_SSEL];
          pl_d        = reg_wdata[`CIA_FLG_PL_HI:`CIA_FLG_PL_LO];
        end
        `CIA_REG_PEND_LO: pend_d[15:0] = (pend_q[15:0] & ~reg_wdata) | hw_raise[15:0];
        `CIA_REG_PEND_HI: begin
          pend_d[19:16] = (pend_q[19:16] & ~reg_wdata[3:0]) | hw_raise[19:16];
          sw_pend_d     = (sw_pend_q & ~reg_wdata[7:4]) | sw_req;
        end
        `CIA_REG_ISP: isp_d = reg_wdata;
        `CIA_REG_USP: usp_d = reg_wdata;
        `CIA_REG_STAT: sp_fault_d = sp_fault_q & ~reg_wdata[`CIA_STAT_SPFAULT];
        default: begin
          for (int i = 0; i < `CIA_N_HW; i++) begin
            if (reg_addr == (`CIA_REG_PRIO_BASE + 8'(i))) begin
              prio_d[i] = reg_wdata[2:0];
            end
          end
        end
      endcase
    end

    // register reads, data stand in the following cycle only
    if (reg_rd) begin
      unique case (reg_addr)
        `CIA_REG_FLAGS: reg_rdata_d = {9'h000, processor_priority_level_q, 1'b0,
                                       1'b0, stack_sel_q, irq_en_q};
        `CIA_REG_PEND_LO: reg_rdata_d = pend_q[15:0];
        `CIA_REG_PEND_HI: reg_rdata_d = {8'h00, sw_pend_q, pend_q[19:16]};
        `CIA_REG_ISP:     reg_rdata_d = isp_q;
        `CIA_REG_USP:     reg_rdata_d = usp_q;
        `CIA_REG_HANDLER: reg_rdata_d = handler_q;
        `CIA_REG_STAT:    reg_rdata_d = {9'h000, sp_fault_q, state_q != cia_pkg::CIA_IDLE,
                                         ack_src_q};
        default: begin
          for (int i = 0; i < `CIA_N_HW; i++) begin
            if (reg_addr == (`CIA_REG_PRIO_BASE + 8'(i))) begin
              reg_rdata_d = {13'h0000, prio_q[i]};
            end
          end
        end
      endcase
    end

    unique case (state_q)
      cia_pkg::CIA_IDLE: begin
        // software traps are not maskable and go ahead of hardware
        if (|sw_pend_q) begin
          accept = 1'b1;
          for (int i = `CIA_N_SW - 1; i >= 0; i--) begin
            if (sw_pend_q[i]) begin
              src = 5'(`CIA_N_HW + i);
            end
          end
          sw_pend_d[src[1:0]] = sw_req[src[1:0]];
          clr_sel = trap_num_q < `CIA_TRAP_U_LIMIT;
        end else if (best_v[`CIA_N_HW]) begin
          accept = 1'b1;
          src    = best_i[`CIA_N_HW];
          // a new edge in the same cycle survives the clear
          pend_d[src] = hw_raise[src];
          clr_sel = 1'b1;
        end
        if (accept) begin
          ctx_flags_d = {9'h000, processor_priority_level_q, 1'b0,
                         1'b0, stack_sel_q, irq_en_q};
          irq_en_d    = 1'b0;
          if (clr_sel) begin
            stack_sel_d = 1'b0;
          end
          ack_d     = 1'b1;
          ack_src_d = src;
          slot_d    = vec_slot(src);
          state_d   = cia_pkg::CIA_PUSH_PC;
        end
      end
      cia_pkg::CIA_PUSH_PC, cia_pkg::CIA_PUSH_FLG: begin
        // push on whichever pointer the select flag now names
        mem_addr_d  = sp_new;
        mem_wdata_d = (state_q == cia_pkg::CIA_PUSH_PC) ? ret_pc : ctx_flags_q;
        mem_we_d    = 1'b1;
        if (stack_sel_q) begin
          usp_d = sp_new;
        end else begin
          isp_d = sp_new;
        end
        // a push below RAM would hit registers; flagged, not stopped
        if (sp_new < `CIA_RAM_BASE) begin
          sp_fault_d = 1'b1;
        end
        state_d = (state_q == cia_pkg::CIA_PUSH_PC) ? cia_pkg::CIA_PUSH_FLG
                                                    : cia_pkg::CIA_FETCH;
      end
      cia_pkg::CIA_FETCH: begin
        mem_addr_d = `CIA_VEC_BASE + {10'h000, slot_q, 2'b00};
        mem_re_d   = 1'b1;
        state_d    = cia_pkg::CIA_WAIT;
      end
      cia_pkg::CIA_WAIT: state_d = cia_pkg::CIA_TAKE;
      cia_pkg::CIA_TAKE: begin
        handler_d       = mem_rdata;
        handler_valid_d = 1'b1;
        state_d         = cia_pkg::CIA_IDLE;
      end
      default: state_d = cia_pkg::CIA_IDLE;
    endcase

    active_sp_d = stack_sel_d ? usp_d : isp_d;
  end

  // ==================================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q     <= cia_pkg::CIA_IDLE;
      ext_s1_q    <= 4'h0;
      ext_s2_q    <= 4'h0;
      ext_s3_q    <= 4'h0;
      key_s1_q    <= 4'h0;
      key_s2_q    <= 4'h0;
      key_s3_q    <= 2'h0;
      pend_q      <= '0;
      sw_pend_q   <= 4'h0;
      trap_num_q  <= 6'h00;
      prio_q      <= '{default: 3'h0};
      irq_en_q    <= `CIA_FLAGS_RESET;
      stack_sel_q <= `CIA_FLAGS_RESET;
      processor_priority_level_q <= `CIA_PL_RESET;
      isp_q       <= `CIA_ISP_RESET;
      usp_q       <= `CIA_USP_RESET;
      ctx_flags_q <= 16'h0000;
      slot_q      <= 4'h0;
      sp_fault_q  <= 1'b0;
      reg_rdata_q <= 16'h0000;
      active_sp_q <= `CIA_ISP_RESET;
      ack_q       <= 1'b0;
      ack_src_q   <= 5'h00;
      handler_q   <= 16'h0000;
      handler_valid_q <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 16'h0000;
      mem_we_q    <= 1'b0;
      mem_re_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      ext_s1_q    <= external_request_lines;
      ext_s2_q    <= ext_s1_q;
      ext_s3_q    <= ext_s2_q;
      key_s1_q    <= key_request_lines;
      key_s2_q    <= key_s1_q;
      key_s3_q    <= key_any;
      pend_q      <= pend_d;
      sw_pend_q   <= sw_pend_d;
      trap_num_q  <= trap_num_d;
      prio_q      <= prio_d;
      irq_en_q    <= irq_en_d;
      stack_sel_q <= stack_sel_d;
      processor_priority_level_q <= pl_d;
      isp_q       <= isp_d;
      usp_q       <= usp_d;
      ctx_flags_q <= ctx_flags_d;
      slot_q      <= slot_d;
      sp_fault_q  <= sp_fault_d;
      reg_rdata_q <= reg_rdata_d;
      active_sp_q <= active_sp_d;
      ack_q       <= ack_d;
      ack_src_q   <= ack_src_d;
      handler_q   <= handler_d;
      handler_valid_q <= handler_valid_d;
      mem_addr_q  <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      mem_we_q    <= mem_we_d;
      mem_re_q    <= mem_re_d;
    end
  end

endmodule : cia_top

/* File: verif/cia_irq_monitor.sv */
// port assertions of the interrupt acceptance unit
`timescale 1ns/1ns
module cia_irq_monitor (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_n,
  // core side
  input wire logic                irq_en_q,
  input wire logic                stack_sel_q,
  input wire cia_pkg::cia_level_t processor_priority_level_q,
  input wire logic                ack_q,
  input wire cia_pkg::cia_src_t   ack_src_q,
  input wire logic [15:0]         handler_q,
  input wire logic                handler_valid_q,
  // memory port
  input wire logic [15:0]         mem_addr_q,
  input wire logic                mem_we_q,
  input wire logic                mem_re_q,
  input wire logic [15:0]         mem_rdata
);
  // ==================================================================
  // helpers
  logic [15:0] vec_exp;
  logic        hw_ack;
  // slot wraps at nine, so software sources reuse the low slots
  assign vec_exp = 16'hffdc + {9'h0, ack_src_q % 5'd9, 2'b00};
  assign hw_ack  = ack_q && (ack_src_q < 5'd20);

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence push_s;
    mem_we_q ##1 mem_we_q ##1 mem_re_q ##2 handler_valid_q;
  endsequence

  // ==================================================================
  // assertions
  en_gate_a: assert property (hw_ack |-> $past(irq_en_q))
    else $error("hardware acceptance while disabled");
  ack_clr_en_a: assert property (ack_q |-> !irq_en_q)
    else $error("enable flag kept on acceptance");
  ack_clr_sel_a: assert property (hw_ack |-> !stack_sel_q)
    else $error("stack select kept on hardware acceptance");
  top_level_a: assert property (hw_ack |-> $past(processor_priority_level_q) != 3'h7)
    else $error("acceptance above top level");
  push_seq_a: assert property (ack_q |=> push_s)
    else $error("push and fetch sequence broken");
  vec_addr_a: assert property (mem_re_q |-> mem_addr_q == vec_exp)
    else $error("vector fetch address wrong");
  handler_load_a: assert property (handler_valid_q |-> handler_q == $past(mem_rdata))
    else $error("handler not taken from fetch");
  src_range_a: assert property (ack_q |-> ack_src_q < 5'd24)
    else $error("accepted source out of range");
endmodule : cia_irq_monitor

bind cia_top cia_irq_monitor u_mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .irq_en_q(irq_en_q), .stack_sel_q(stack_sel_q),
  .processor_priority_level_q(processor_priority_level_q), .ack_q(ack_q),
  .ack_src_q(ack_src_q), .handler_q(handler_q), .handler_valid_q(handler_valid_q),
  .mem_addr_q(mem_addr_q), .mem_we_q(mem_we_q), .mem_re_q(mem_re_q), .mem_rdata(mem_rdata)
);

/* File: verif/cia_vec_mem_model.sv */
// memory model holding the fixed vector table
`timescale 1ns/1ns
module cia_vec_mem_model (
  // clock
  input wire logic  ref_clk,
  // memory port
  input wire logic [15:0] mem_addr_q,
  input wire logic        mem_re_q,
  output logic     [15:0] mem_rdata
);
  initial mem_rdata = 16'h0000;
  // data valid one cycle only; afterwards it toggles so stale reads show
  always @(posedge ref_clk) begin
    if (mem_re_q) begin
      mem_rdata <= {8'h80, mem_addr_q[7:0]};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : cia_vec_mem_model

/* File: verif/tb_top.sv */
// self-checking bench of the interrupt acceptance unit
`timescale 1ns/1ns
`include "cia_consts.svh"
module tb_top;
  typedef struct packed {
    cia_pkg::cia_src_t   src;
    cia_pkg::cia_level_t lvl;
    logic [15:0]         vec;
  } cia_row_t;
  logic                ref_clk, rst_n, reg_wr, reg_rd, irq_en_q, stack_sel_q, ack_q;
  logic                handler_valid_q, mem_we_q, mem_re_q;
  logic [7:0]          reg_addr;
  logic [15:0]         reg_wdata, reg_rdata_q, ret_pc, active_sp_q, handler_q;
  logic [15:0]         mem_addr_q, mem_wdata_q, mem_rdata, exp_isp, rd_v;
  logic [13:0]         int_req;
  logic [3:0]          external_request_lines, key_request_lines, sw_req;
  logic [5:0]          trap_num;
  cia_pkg::cia_level_t processor_priority_level_q;
  cia_pkg::cia_src_t   ack_src_q;
  integer              failures, checks;
  cia_row_t            rows [9];

  cia_top u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .int_req(int_req),
    .external_request_lines(external_request_lines), .key_request_lines(key_request_lines),
    .sw_req(sw_req), .trap_num(trap_num), .ret_pc(ret_pc), .irq_en_q(irq_en_q),
    .stack_sel_q(stack_sel_q), .processor_priority_level_q(processor_priority_level_q),
    .active_sp_q(active_sp_q), .ack_q(ack_q), .ack_src_q(ack_src_q), .handler_q(handler_q),
    .handler_valid_q(handler_valid_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_we_q(mem_we_q), .mem_re_q(mem_re_q), .mem_rdata(mem_rdata)
  );
  cia_vec_mem_model u_mem (
    .ref_clk(ref_clk), .mem_addr_q(mem_addr_q), .mem_re_q(mem_re_q), .mem_rdata(mem_rdata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==================================================================
  // tasks
  task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata_q;
  endtask : rd

  // pins held three cycles to clear the two-stage synchroniser
  task fire(input int s);
    @(posedge ref_clk);
    if (s < 14) int_req <= 14'h1 << s;
    else if (s < 18) external_request_lines <= 4'h1 << (s - 14);
    else if (s < 20) key_request_lines <= (s == 18) ? 4'h1 : 4'h4;
    else sw_req <= 4'h1 << (s - 20);
    if (s < 14 || s > 19) @(posedge ref_clk);
    else repeat (3) @(posedge ref_clk);
    int_req                <= 14'h0000;
    external_request_lines <= 4'h0;
    key_request_lines      <= 4'h0;
    sw_req                 <= 4'h0;
  endtask : fire

  task quiet;
    logic seen;
    seen = 1'b0;
    repeat (12) @(negedge ref_clk) if (ack_q !== 1'b0) seen = 1'b1;
    cmp("no ack", 16'h0, 16'(seen));
  endtask : quiet

  task acc(input int s, input logic sel, input logic [15:0] sp, input logic [15:0] vec);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (ack_q !== 1'b1 && n < 40);
    if (ack_q !== 1'b1) begin
      failures++;
      wrap_up();
    end
    cmp("source", 16'(s), 16'(ack_src_q));
    cmp("enable", 16'h0, 16'(irq_en_q));
    cmp("select", 16'(sel), 16'(stack_sel_q));
    @(negedge ref_clk);
    cmp("push addr", sp - 16'h2, mem_addr_q);
    cmp("push pc", ret_pc, mem_wdata_q);
    @(negedge ref_clk);
    cmp("push flags", sp - 16'h4, mem_addr_q);
    cmp("push we", 16'h1, 16'(mem_we_q));
    @(negedge ref_clk);
    cmp("fetch", vec, mem_addr_q & {16{mem_re_q}});
    repeat (2) @(negedge ref_clk);
    cmp("handler", {8'h80, vec[7:0]}, handler_q & {16{handler_valid_q}});
  endtask : acc

  // ==================================================================
  // main sequence
  initial begin
    failures = 0;
    checks = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    int_req = 14'h0000;
    external_request_lines = 4'h0;
    key_request_lines = 4'h0;
    sw_req = 4'h0;
    trap_num = 6'h00;
    ret_pc = 16'h1000;
    exp_isp = `CIA_ISP_RESET;
    rows = '{'{5'h00, 3'h1, 16'hffdc}, '{5'h05, 3'h2, 16'hfff0}, '{5'h0d, 3'h3, 16'hffec},
             '{5'h0e, 3'h4, 16'hfff0}, '{5'h11, 3'h5, 16'hfffc}, '{5'h12, 3'h6, 16'hffdc},
             '{5'h13, 3'h7, 16'hffe0}, '{5'h14, 3'h1, 16'hffe4}, '{5'h17, 3'h1, 16'hfff0}};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`CIA_REG_FLAGS, rd_v);
    cmp("flags", 16'h0000, rd_v);
    rd(`CIA_REG_ISP, rd_v);
    cmp("isp", 16'h0800, rd_v);
    @(negedge ref_clk);
    cmp("rdata idle", 16'h0000, reg_rdata_q);
    cmp("sp out", 16'h0800, active_sp_q);
    rd(8'h40, rd_v);
    cmp("unmapped", 16'h0000, rd_v);
    $display("test reset done");
    wr(`CIA_REG_FLAGS, 16'h0074);
    rd(`CIA_REG_FLAGS, rd_v);
    cmp("flags", 16'h0070, rd_v & 16'hfffb);
    cmp("level", 16'h7, 16'(processor_priority_level_q));
    $display("test flags done");
    foreach (rows[i]) begin
      if (rows[i].src < 5'd20) wr(8'h10 + 8'(rows[i].src), 16'(rows[i].lvl));
      wr(`CIA_REG_FLAGS, 16'h0001);
      ret_pc <= 16'h1000 + 16'(i);
      fire(int'(rows[i].src));
      acc(int'(rows[i].src), 1'b0, exp_isp, rows[i].vec);
      exp_isp = exp_isp - 16'h4;
    end
    $display("test sources done");
    wr(8'h13, 16'h0005);
    wr(`CIA_REG_FLAGS, 16'h0050);
    fire(3);
    quiet();
    wr(`CIA_REG_FLAGS, 16'h0051);
    quiet();
    wr(`CIA_REG_FLAGS, 16'h0041);
    acc(3, 1'b0, exp_isp, 16'hffe8);
    exp_isp = exp_isp - 16'h4;
    $display("test masking done");
    wr(8'h12, 16'h0003);
    wr(8'h17, 16'h0006);
    wr(8'h19, 16'h0006);
    wr(`CIA_REG_FLAGS, 16'h0000);
    int_req <= 14'h0284;
    @(posedge ref_clk);
    int_req <= 14'h0000;
    wr(`CIA_REG_FLAGS, 16'h0001);
    acc(7, 1'b0, exp_isp, 16'hfff8);
    wr(`CIA_REG_FLAGS, 16'h0001);
    acc(9, 1'b0, exp_isp - 16'h4, 16'hffdc);
    wr(`CIA_REG_FLAGS, 16'h0001);
    acc(2, 1'b0, exp_isp - 16'h8, 16'hffe4);
    exp_isp = exp_isp - 16'hc;
    $display("test arbitration done");
    wr(`CIA_REG_USP, 16'h0600);
    wr(`CIA_REG_FLAGS, 16'h0003);
    trap_num <= 6'd40;
    fire(22);
    acc(22, 1'b1, 16'h0600, 16'hffec);
    wr(`CIA_REG_FLAGS, 16'h0003);
    trap_num <= 6'd31;
    fire(21);
    acc(21, 1'b0, exp_isp, 16'hffe8);
    rd(`CIA_REG_HANDLER, rd_v);
    cmp("handler reg", 16'h80e8, rd_v);
    rd(`CIA_REG_STAT, rd_v);
    cmp("status", 16'h0015, rd_v);
    $display("test traps done");
    wrap_up();
  end
endmodule : tb_top
